// ---- pkg/pfs_params.svh ----
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH

// ****************************************
// register map (byte offsets on the apb bus)
// ****************************************
`define PFS_ADDR_W 8
`define PFS_OFS_J_SEL 8'h00
`define PFS_OFS_K_SEL 8'h04
`define PFS_OFS_L_SEL 8'h08
`define PFS_OFS_SC_SEL 8'h0C
`define PFS_OFS_J_DAT 8'h10
`define PFS_OFS_K_DAT 8'h14
`define PFS_OFS_L_DAT 8'h18
`define PFS_OFS_SC_DAT 8'h1C

// ****************************************
// power-on reset values
// ****************************************
`define PFS_RST_J_SEL 16'h0000
`define PFS_RST_K_SEL 16'h0000
`define PFS_RST_L_SEL 16'hAA00
`define PFS_RST_SC_SEL 16'hA888
`define PFS_RST_DAT 8'h00

// ****************************************
// field layout and port indices
// ****************************************
`define PFS_SEL_W 16
`define PFS_DAT_W 8
`define PFS_PINS 8
`define PFS_PORTS 4
`define PFS_PORT_J 0
`define PFS_PORT_K 1
`define PFS_PORT_L 2
`define PFS_PORT_SC 3
`define PFS_CHANNELS 3
`define PFS_RX_IGNORED_LEVEL 1'b1

`endif

// ---- pkg/pfs_pkg.sv ----
package pfs_pkg;

  // ****************************************
  // decoded pin modes
  // ****************************************
  typedef enum logic [2:0] {
    PFS_FUNC = 3'b000,
    PFS_OUT = 3'b001,
    PFS_IN_PU = 3'b010,
    PFS_IN = 3'b011,
    PFS_NONE = 3'b100
  } pfs_mode_e;

  // ****************************************
  // field decoding families
  // ****************************************
  typedef enum logic [2:0] {
    PFS_K_FULL = 3'b000,
    PFS_K_J3 = 3'b001,
    PFS_K_NF = 3'b010,
    PFS_K_LLO = 3'b011,
    PFS_K_LHI = 3'b100,
    PFS_K_SC7 = 3'b101,
    PFS_K_SC6 = 3'b110
  } pfs_kind_e;

  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
    logic fin;
    logic rd;
  } pfs_pin_s;

endpackage : pfs_pkg

// ---- core/pfs_pin_select.sv ----
// Overview of operation
// - four 16-bit read/write pin select registers, one per port
// - pin n uses bits 2n+1 (high) and 2n (low)
// - port j pins 0,2,6,7: function, output, input pull-up, input
// - port j pin 3: function, output, high bit set gives input without pull-up
// - port j pins 1,4,5: 00 no function, 01 output, high codes reserved
// - port k all pins: function, output, input pull-up, input
// - port l: low pins function or input, high pins input, no pull-ups
// - power-on reset clears port j and port k selects
// - power-on reset loads port l select with AA00
// - power-on reset loads serial select with A888
// - only power-on reset reinitialises selects, not manual reset or standby
// - serial pin 7 function or input, pins 1,3,5 four-way, pin 6 output or input
// - transmit pin: function, port output, or high impedance for high codes
// - receive pin: function, level ignored, input pull-up, input
// - transmit enable forces transmit pin to peripheral output
// - receive enable forces receive pin to peripheral input
// - in function or input mode transmit pin drives only while enabled
// - each channel's transmit and receive share one data bit, no simultaneous use
// - data read returns pin level in input modes, stored bit otherwise
//
// The APB slave port and the placing of the registers are this design's own decisions.
`include "pfs_params.svh"

module pfs_pin_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PFS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] j_pin_in,
  output logic [7:0] j_pin_out,
  output logic [7:0] j_pin_oe,
  output logic [7:0] j_pin_pullup,
  input wire logic [7:0] j_func_out,
  input wire logic [7:0] j_func_oe,
  output logic [7:0] j_func_in,
  input wire logic [7:0] k_pin_in,
  output logic [7:0] k_pin_out,
  output logic [7:0] k_pin_oe,
  output logic [7:0] k_pin_pullup,
  input wire logic [7:0] k_func_out,
  input wire logic [7:0] k_func_oe,
  output logic [7:0] k_func_in,
  input wire logic [7:0] l_pin_in,
  output logic [7:0] l_pin_out,
  output logic [7:0] l_pin_oe,
  output logic [7:0] l_pin_pullup,
  input wire logic [7:0] l_func_out,
  input wire logic [7:0] l_func_oe,
  output logic [7:0] l_func_in,
  input wire logic [7:0] sc_pin_in,
  output logic [7:0] sc_pin_out,
  output logic [7:0] sc_pin_oe,
  output logic [7:0] sc_pin_pullup,
  input wire logic [7:0] sc_func_out,
  input wire logic [7:0] sc_func_oe,
  output logic [7:0] sc_func_in,
  input wire logic [2:0] rxd_in,
  output logic [2:0] rxd_pullup,
  output logic [2:0] rx_func_in,
  input wire logic [2:0] transmit_enable,
  input wire logic [2:0] receive_enable
);

  // ****************************************
  // field decoding
  // ****************************************

  // which decoding family a given pin field follows
  function automatic pfs_pkg::pfs_kind_e kind_of(input int p, input int n);
    pfs_pkg::pfs_kind_e k;
    k = pfs_pkg::PFS_K_FULL;
    if (p == `PFS_PORT_J) begin
      if (n == 3) begin
        k = pfs_pkg::PFS_K_J3;
      end else if (n == 1 || n == 4 || n == 5) begin
        k = pfs_pkg::PFS_K_NF;
      end
    end else if (p == `PFS_PORT_L) begin
      k = (n < 4) ? pfs_pkg::PFS_K_LLO : pfs_pkg::PFS_K_LHI;
    end else if (p == `PFS_PORT_SC) begin
      if (n == 7) begin
        k = pfs_pkg::PFS_K_SC7;
      end else if (n == 6) begin
        k = pfs_pkg::PFS_K_SC6;
      end
    end
    return k;
  endfunction : kind_of

  // reserved codes decode to none: pin released, input not seen
  function automatic pfs_pkg::pfs_mode_e decode(input pfs_pkg::pfs_kind_e k,
                                                input logic [1:0] code);
    pfs_pkg::pfs_mode_e m;
    m = pfs_pkg::PFS_NONE;
    case (k)
      pfs_pkg::PFS_K_FULL: begin
        m = pfs_pkg::pfs_mode_e'({1'b0, code});
      end
      pfs_pkg::PFS_K_J3: begin
        m = code[1] ? pfs_pkg::PFS_IN : pfs_pkg::pfs_mode_e'({1'b0, code});
      end
      pfs_pkg::PFS_K_NF: begin
        m = (code == 2'b01) ? pfs_pkg::PFS_OUT : pfs_pkg::PFS_NONE;
      end
      pfs_pkg::PFS_K_LLO: begin
        if (code[1]) begin
          m = pfs_pkg::PFS_IN;
        end else if (code == 2'b00) begin
          m = pfs_pkg::PFS_FUNC;
        end
      end
      pfs_pkg::PFS_K_LHI: begin
        m = code[1] ? pfs_pkg::PFS_IN : pfs_pkg::PFS_NONE;
      end
      pfs_pkg::PFS_K_SC7: begin
        m = (code == 2'b01) ? pfs_pkg::PFS_NONE : pfs_pkg::pfs_mode_e'({1'b0, code});
      end
      pfs_pkg::PFS_K_SC6: begin
        m = (code == 2'b00) ? pfs_pkg::PFS_NONE : pfs_pkg::pfs_mode_e'({1'b0, code});
      end
      default: begin
        m = pfs_pkg::PFS_NONE;
      end
    endcase
    return m;
  endfunction : decode

  // pin behaviour for one decoded mode
  function automatic pfs_pkg::pfs_pin_s pin_logic(input pfs_pkg::pfs_mode_e m,
                                                   input logic dat, input logic lvl,
                                                   input logic fo, input logic foe);
    pfs_pkg::pfs_pin_s r;
    r = '0;
    r.rd = dat;
    case (m)
      pfs_pkg::PFS_FUNC: begin
        r.out = fo;
        r.oe = foe;
        r.fin = lvl;
      end
      pfs_pkg::PFS_OUT: begin
        r.out = dat;
        r.oe = 1'b1;
      end
      pfs_pkg::PFS_IN_PU: begin
        r.pu = 1'b1;
        r.rd = lvl;
      end
      pfs_pkg::PFS_IN: begin
        r.rd = lvl;
      end
      default: begin
        r.rd = dat;
      end
    endcase
    return r;
  endfunction : pin_logic

  // ****************************************
  // state
  // ****************************************
  logic [`PFS_PORTS-1:0][`PFS_SEL_W-1:0] sel_q;
  logic [`PFS_PORTS-1:0][`PFS_DAT_W-1:0] dat_q;
  logic [`PFS_PORTS-1:0][7:0] pin_s1_q;
  logic [`PFS_PORTS-1:0][7:0] pin_s2_q;
  logic [2:0] rxd_s1_q;
  logic [2:0] rxd_s2_q;
  logic [`PFS_PORTS-1:0][7:0] fo;
  logic [`PFS_PORTS-1:0][7:0] foe;
  pfs_pkg::pfs_mode_e mode [`PFS_PORTS][`PFS_PINS];
  pfs_pkg::pfs_pin_s res [`PFS_PORTS][`PFS_PINS];
  pfs_pkg::pfs_pin_s fin_d [`PFS_PORTS][`PFS_PINS];
  logic [2:0] rxpu_d;
  logic [2:0] rxfi_d;
  logic [`PFS_PORTS-1:0][7:0] out_q;
  logic [`PFS_PORTS-1:0][7:0] oe_q;
  logic [`PFS_PORTS-1:0][7:0] pu_q;
  logic [`PFS_PORTS-1:0][7:0] fi_q;
  logic [2:0] rxpu_q;
  logic [2:0] rxfi_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [2:0] idx;
  logic hit;
  logic wr_en;
  logic [31:0] rd_word;

  assign fo = {sc_func_out, l_func_out, k_func_out, j_func_out};
  assign foe = {sc_func_oe, l_func_oe, k_func_oe, j_func_oe};

  // ****************************************
  // pin input synchronisers
  // ****************************************

  // pins are asynchronous to pclk, so two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin : sync_regs
    if (!presetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      rxd_s1_q <= '0;
      rxd_s2_q <= '0;
    end else begin
      pin_s1_q <= {sc_pin_in, l_pin_in, k_pin_in, j_pin_in};
      pin_s2_q <= pin_s1_q;
      rxd_s1_q <= rxd_in;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  // ****************************************
  // per-pin decode
  // ****************************************
  for (genvar p = 0; p < `PFS_PORTS; p++) begin : g_port
    for (genvar n = 0; n < `PFS_PINS; n++) begin : g_pin
      // field of pin n sits at bits 2n+1 and 2n
      assign mode[p][n] = decode(kind_of(p, n), sel_q[p][2*n+1 -: 2]);
      assign res[p][n] = pin_logic(mode[p][n], dat_q[p][n], pin_s2_q[p][n],
                                   fo[p][n], foe[p][n]);
    end
  end

  // ****************************************
  // serial channel overrides
  // ****************************************

  // fields 0, 2 and 4 each steer one transmit and one receive pin
  always_comb begin : serial_mux
    fin_d = res;
    rxpu_d = '0;
    rxfi_d = '0;
    for (int c = 0; c < `PFS_CHANNELS; c++) begin
      // transmit pin: never an input, never pulled up
      fin_d[`PFS_PORT_SC][2*c].fin = 1'b0;
      fin_d[`PFS_PORT_SC][2*c].pu = 1'b0;
      if (transmit_enable[c]) begin
        fin_d[`PFS_PORT_SC][2*c].out = sc_func_out[2*c];
        fin_d[`PFS_PORT_SC][2*c].oe = 1'b1;
      end else if (mode[`PFS_PORT_SC][2*c] == pfs_pkg::PFS_OUT) begin
        fin_d[`PFS_PORT_SC][2*c].out = dat_q[`PFS_PORT_SC][2*c];
        fin_d[`PFS_PORT_SC][2*c].oe = 1'b1;
      end else begin
        fin_d[`PFS_PORT_SC][2*c].out = 1'b0;
        fin_d[`PFS_PORT_SC][2*c].oe = 1'b0;
      end
      // receive pin; the shared data bit reads it only in input modes
      fin_d[`PFS_PORT_SC][2*c].rd = dat_q[`PFS_PORT_SC][2*c];
      case (mode[`PFS_PORT_SC][2*c])
        pfs_pkg::PFS_FUNC: begin
          rxfi_d[c] = rxd_s2_q[c];
        end
        pfs_pkg::PFS_OUT: begin
          rxfi_d[c] = `PFS_RX_IGNORED_LEVEL;
        end
        pfs_pkg::PFS_IN_PU: begin
          rxpu_d[c] = 1'b1;
          fin_d[`PFS_PORT_SC][2*c].rd = rxd_s2_q[c];
        end
        default: begin
          fin_d[`PFS_PORT_SC][2*c].rd = rxd_s2_q[c];
        end
      endcase
      if (receive_enable[c]) begin
        rxfi_d[c] = rxd_s2_q[c];
      end
    end
  end

  // ****************************************
  // registered pin outputs
  // ****************************************

  // outputs are flopped to keep pins glitch free while fields change
  always_ff @(posedge pclk or negedge presetn) begin : pin_regs
    if (!presetn) begin
      out_q <= '0;
      oe_q <= '0;
      pu_q <= '0;
      fi_q <= '0;
      rxpu_q <= '0;
      rxfi_q <= '0;
    end else begin
      for (int p = 0; p < `PFS_PORTS; p++) begin
        for (int n = 0; n < `PFS_PINS; n++) begin
          out_q[p][n] <= fin_d[p][n].out;
          oe_q[p][n] <= fin_d[p][n].oe;
          pu_q[p][n] <= fin_d[p][n].pu;
          fi_q[p][n] <= fin_d[p][n].fin;
        end
      end
      rxpu_q <= rxpu_d;
      rxfi_q <= rxfi_d;
    end
  end

  assign j_pin_out = out_q[`PFS_PORT_J];
  assign j_pin_oe = oe_q[`PFS_PORT_J];
  assign j_pin_pullup = pu_q[`PFS_PORT_J];
  assign j_func_in = fi_q[`PFS_PORT_J];
  assign k_pin_out = out_q[`PFS_PORT_K];
  assign k_pin_oe = oe_q[`PFS_PORT_K];
  assign k_pin_pullup = pu_q[`PFS_PORT_K];
  assign k_func_in = fi_q[`PFS_PORT_K];
  assign l_pin_out = out_q[`PFS_PORT_L];
  assign l_pin_oe = oe_q[`PFS_PORT_L];
  assign l_pin_pullup = pu_q[`PFS_PORT_L];
  assign l_func_in = fi_q[`PFS_PORT_L];
  assign sc_pin_out = out_q[`PFS_PORT_SC];
  assign sc_pin_oe = oe_q[`PFS_PORT_SC];
  assign sc_pin_pullup = pu_q[`PFS_PORT_SC];
  assign sc_func_in = fi_q[`PFS_PORT_SC];
  assign rxd_pullup = rxpu_q;
  assign rx_func_in = rxfi_q;

  // ****************************************
  // apb slave
  // ****************************************

  // eight word slots from offset zero; anything else errors
  assign idx = paddr[4:2];
  assign hit = (paddr[`PFS_ADDR_W-1:5] == '0) && (paddr[1:0] == 2'b00);
  assign wr_en = psel && penable && pready_q && pwrite && hit;

  // read data: select registers return written bits untouched
  always_comb begin : read_mux
    rd_word = '0;
    if (idx[2]) begin
      for (int n = 0; n < `PFS_PINS; n++) begin
        rd_word[n] = fin_d[idx[1:0]][n].rd;
      end
    end else begin
      rd_word[`PFS_SEL_W-1:0] = sel_q[idx[1:0]];
    end
  end

  // read data is captured in the setup cycle; one access cycle, no waits
  always_ff @(posedge pclk or negedge presetn) begin : apb_regs
    if (!presetn) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !hit;
      if (psel && !penable && !pwrite && hit) begin
        prdata_q <= rd_word;
      end else if (psel && !penable) begin
        prdata_q <= '0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // presetn is the power-on reset; manual reset and standby never reach here
  always_ff @(posedge pclk or negedge presetn) begin : sel_regs
    if (!presetn) begin
      sel_q[`PFS_PORT_J] <= `PFS_RST_J_SEL;
      sel_q[`PFS_PORT_K] <= `PFS_RST_K_SEL;
      sel_q[`PFS_PORT_L] <= `PFS_RST_L_SEL;
      sel_q[`PFS_PORT_SC] <= `PFS_RST_SC_SEL;
    end else if (wr_en && !idx[2]) begin
      // reserved codes are stored as written; decode keeps them inert
      if (pstrb[0]) begin
        sel_q[idx[1:0]][7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        sel_q[idx[1:0]][15:8] <= pwdata[15:8];
      end
    end
  end

  // data bits: drive the pin in output mode, kept in every mode
  always_ff @(posedge pclk or negedge presetn) begin : dat_regs
    if (!presetn) begin
      dat_q <= {`PFS_PORTS{`PFS_RST_DAT}};
    end else if (wr_en && idx[2] && pstrb[0]) begin
      dat_q[idx[1:0]] <= pwdata[7:0];
    end
  end

endmodule : pfs_pin_select

// ---- testbench/pfs_pin_select_chk.sv ----
`include "pfs_params.svh"

// ****
// port checks of the pin select block
// ****
module pfs_pin_select_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [`PFS_ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] j_pin_oe,
  input wire logic [7:0] j_pin_pullup,
  input wire logic [7:0] k_pin_oe,
  input wire logic [7:0] k_pin_pullup,
  input wire logic [7:0] l_pin_oe,
  input wire logic [7:0] l_pin_pullup,
  input wire logic [7:0] sc_pin_out,
  input wire logic [7:0] sc_pin_oe,
  input wire logic [7:0] sc_func_out,
  input wire logic [2:0] rxd_in,
  input wire logic [2:0] rx_func_in,
  input wire logic [2:0] transmit_enable,
  input wire logic [2:0] receive_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // bus answer: one access cycle, error only off the map or misaligned
  a_ready_one_cycle: assert property (
    psel && !penable |=> pready ##1 !pready) else $error("pready not one cycle");
  a_ready_cause: assert property (
    pready |-> $past(psel) && !$past(penable)) else $error("pready without setup");
  a_err_off_map: assert property (
    psel && !penable |=> pslverr == (($past(paddr) & 8'hE3) != 8'h00))
    else $error("pslverr wrong");
  // channel enables win over the select field
  a_tx_enable_drive: assert property (
    transmit_enable[0] |=> sc_pin_oe[0] && sc_pin_out[0] == $past(sc_func_out[0]))
    else $error("tx pin not driven");
  a_rx_enable_route: assert property (
    (receive_enable[1] && $stable(rxd_in[1]))[*4] |-> rx_func_in[1] == rxd_in[1])
    else $error("rx pin not routed");
  // a pulled-up input is never driven at the same time
  a_pull_no_drive: assert property (
    ((j_pin_pullup & j_pin_oe) | (k_pin_pullup & k_pin_oe)) == 8'h00)
    else $error("pull-up on driven pin");
  a_port_l_input: assert property (
    l_pin_pullup == 8'h00 && l_pin_oe[7:4] == 4'h0) else $error("port l drive or pull");
  a_j_pull_pins: assert property (
    (j_pin_pullup & 8'h3A) == 8'h00) else $error("port j pull-up on wrong pin");
endmodule : pfs_pin_select_chk

bind pfs_pin_select pfs_pin_select_chk i_pfs_pin_select_chk (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .j_pin_oe,
  .j_pin_pullup, .k_pin_oe, .k_pin_pullup, .l_pin_oe, .l_pin_pullup, .sc_pin_out,
  .sc_pin_oe, .sc_func_out, .rxd_in, .rx_func_in, .transmit_enable, .receive_enable);

// ---- testbench/pfs_pad_model.sv ----
// ****
// pads and the board behind them
// ****
module pfs_pad_model #(
  parameter int W = 35
) (
  input wire logic pclk,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] pu,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [W-1:0] flt_q = '0;

  // an open pin has no level, so it wanders rather than settle by luck
  always @(posedge pclk) begin
    flt_q <= ~flt_q;
  end

  // own driver first, then the board, then the pull-up
  assign lvl = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu | flt_q));
endmodule : pfs_pad_model

// ---- testbench/pfs_pin_select_tb.sv ----
module pfs_pin_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // stimulus and observed signals
  // ****
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] fo = 8'h00;
  logic [7:0] foe = 8'h21;
  logic [2:0] te = 3'h0;
  logic [2:0] re = 3'h0;
  logic [34:0] ext_en = 35'h7FFFFFF00; // port j left open
  logic [34:0] ext_val = 35'h0;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr;
  logic [7:0] j_pin_out, j_pin_oe, j_pin_pullup, j_func_in;
  logic [7:0] k_pin_out, k_pin_oe, k_pin_pullup, k_func_in;
  logic [7:0] l_pin_out, l_pin_oe, l_pin_pullup, l_func_in;
  logic [7:0] sc_pin_out, sc_pin_oe, sc_pin_pullup, sc_func_in;
  logic [2:0] rxd_pullup, rx_func_in;
  wire logic [7:0] j_pin_in, k_pin_in, l_pin_in, sc_pin_in;
  wire logic [2:0] rxd_in;
  int fails = 0;
  int checks = 0;

  always #50 pclk = ~pclk;

  pfs_pin_select i_pfs_pin_select (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .j_pin_in, .j_pin_out, .j_pin_oe, .j_pin_pullup, .j_func_in,
    .j_func_out(fo), .j_func_oe(foe), .k_pin_in, .k_pin_out, .k_pin_oe, .k_pin_pullup,
    .k_func_in, .k_func_out(fo), .k_func_oe(foe), .l_pin_in, .l_pin_out, .l_pin_oe,
    .l_pin_pullup, .l_func_in, .l_func_out(fo), .l_func_oe(foe), .sc_pin_in,
    .sc_pin_out, .sc_pin_oe, .sc_pin_pullup, .sc_func_in, .sc_func_out(fo),
    .sc_func_oe(foe), .rxd_in, .rxd_pullup, .rx_func_in, .transmit_enable(te),
    .receive_enable(re));

  pfs_pad_model #(.W(35)) i_pfs_pad_model (
    .pclk, .ext_en, .ext_val,
    .oe({3'h0, sc_pin_oe, l_pin_oe, k_pin_oe, j_pin_oe}),
    .out({3'h0, sc_pin_out, l_pin_out, k_pin_out, j_pin_out}),
    .pu({rxd_pullup, sc_pin_pullup, l_pin_pullup, k_pin_pullup, j_pin_pullup}),
    .lvl({rxd_in, sc_pin_in, l_pin_in, k_pin_in, j_pin_in}));

  // ****
  // bus and check tasks
  // ****
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // request held until pready is seen; an idle edge keeps drivers apart
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      test_done();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic rdv(input logic [7:0] a, input logic [31:0] exp, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, rdata, exp);
  endtask : rdv

  // ****
  // main sequence
  // ****
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    ext_val[23:16] <= 8'h50;
    tick(4);
    rdv(8'h00, 32'h0, "j_sel");
    rdv(8'h04, 32'h0, "k_sel");
    rdv(8'h08, 32'hAA00, "l_sel");
    rdv(8'h0C, 32'hA888, "sc_sel");
    rdv(8'h18, 32'h50, "l_dat");
    // off-map and misaligned places answer with an error
    xfer(1'b1, 8'h20, 32'hFFFF);
    chk("wr_err", rerr, 1'b1);
    xfer(1'b0, 8'h06, 32'h0);
    chk("rd_err", rerr, 1'b1);
    chk("rd_val", rdata, 32'h0);
    // no-function pins only ever get 00 or 01, so no field holds a reserved code
    xfer(1'b1, 8'h00, 32'hF5F7);
    rdv(8'h00, 32'hF5F7, "j_sel");
    pstrb <= 4'h2;
    xfer(1'b1, 8'h04, 32'h5555);
    pstrb <= 4'hF;
    rdv(8'h04, 32'h5500, "k_sel");
    // port k: every code twice
    fo <= 8'h20;
    ext_val[15:8] <= 8'h48;
    xfer(1'b1, 8'h14, 32'h12);
    xfer(1'b1, 8'h04, 32'hB1E4);
    tick(5);
    chk("k_oe", k_pin_oe, 8'h33);
    chk("k_out", k_pin_out & 8'h33, 8'h32);
    chk("k_pu", k_pin_pullup, 8'h84);
    chk("k_fin", k_func_in, 8'h20);
    rdv(8'h14, 32'h5A, "k_dat");
    // port j: pin 3 input has no pull-up, no-function pins 1 and 5 released, pin 4 output
    xfer(1'b1, 8'h10, 32'h40);
    xfer(1'b1, 8'h00, 32'h91B2);
    tick(5);
    chk("j_pu", j_pin_pullup, 8'h81);
    chk("j_oe", j_pin_oe, 8'h50);
    chk("j_out", j_pin_out & 8'h50, 8'h40);
    chk("j_fin", j_func_in, 8'h00);
    // port l: inputs read the pin, function pins the stored bit
    xfer(1'b1, 8'h18, 32'h03);
    xfer(1'b1, 8'h08, 32'hFFF0);
    ext_val[23:16] <= 8'hC6;
    tick(5);
    chk("l_oe", l_pin_oe, 8'h01);
    chk("l_out", l_pin_out, 8'h00);
    chk("l_fin", l_func_in, 8'h02);
    rdv(8'h18, 32'hC7, "l_dat");
    // serial pins with enables off, then on
    fo <= 8'h31;
    ext_val[34:24] <= 11'h500;
    xfer(1'b1, 8'h1C, 32'hFF);
    xfer(1'b1, 8'h0C, 32'h9297);
    tick(5);
    chk("sc_oe", sc_pin_oe, 8'h66);
    chk("sc_pu", sc_pin_pullup & 8'hEA, 8'h88);
    chk("sc_fin", sc_func_in, 8'h20);
    chk("rx_pu", rxd_pullup, 3'h4);
    chk("rx_fin", rx_func_in, 3'h2);
    rdv(8'h1C, 32'h77, "sc_dat");
    re <= 3'h7;
    te <= 3'h7;
    tick(5);
    chk("rx_fin", rx_func_in, 3'h5);
    chk("sc_oe", sc_pin_oe, 8'h77);
    chk("sc_out", sc_pin_out & 8'h15, 8'h11);
    // a second power-on reset restores the selects
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(1);
    rdv(8'h0C, 32'hA888, "sc_sel");
    rdv(8'h00, 32'h0, "j_sel");
    test_done();
  end
endmodule : pfs_pin_select_tb
